// file: verilog/gpio_params.svh
// Purpose: Register offsets, field positions and reset values for the
//          two-port pin block.
// Assumes: Offsets are register indices; byte address is four times these.
// Notes:   Definitions only.
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define P4_DIR_IDX 20'hE_E003
`define P4_DATA_IDX 20'hF_FFD3
`define P4_PULLUP_IDX 20'hE_E03E
`define P6_DIR_IDX 20'hE_E005
`define P6_DATA_IDX 20'hF_FFD5
`define CTRL_IDX 20'hE_E0F0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_WIDE_BIT 0
`define CTRL_STOP_BIT 1
`define P6_FIXED_BIT 7

// ----------------------------------------------------------------------
// Reset values and read constants
// ----------------------------------------------------------------------
`define P4_DIR_RST 8'h00
`define P4_DATA_RST 8'h00
`define P4_PULLUP_RST 8'h00
`define P6_DIR_RST 8'h80
`define P6_DATA_RST 8'h80
`define WO_READ_VAL 8'hFF

`endif

// file: verilog/gpio_types_pkg.sv
// Purpose: Shared types of the two-port pin block.
// Assumes: Nothing.
// Notes:   Used by scoped name only.
package gpio_types_pkg;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_P4_DIR,
    SEL_P4_DATA,
    SEL_P4_PULLUP,
    SEL_P6_DIR,
    SEL_P6_DATA,
    SEL_CTRL
  } reg_sel_t;

endpackage

// file: verilog/sync2_bits.sv
// Purpose: Two-flop synchroniser for a group of independent levels.
// Assumes: Each bit is an unrelated level; no bus coherence.
// Notes:   First stage is read only by the second stage.
`timescale 1ns/1ps
module sync2_bits #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
    end
    else
    begin
      stage1_q <= async_in;
      stage2_q <= stage1_q;
    end
  end

  assign sync_out = stage2_q;

endmodule

// file: verilog/avmm_wait_ack.sv
// Purpose: Avalon-MM waitrequest pacing, one wait state per access.
// Assumes: Master holds the request until it sees waitrequest low.
// Notes:   prepare_out marks the cycle to capture read data.
`timescale 1ns/1ps
module avmm_wait_ack (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic request_in,
  output logic waitrequest_out,
  output logic prepare_out,
  output logic accept_out
);

  logic wait_q;
  logic wait_d;

  assign prepare_out = request_in & wait_q;
  assign accept_out = request_in & ~wait_q;
  // Back to waiting after each accept, so every access costs one wait
  assign wait_d = ~prepare_out;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      wait_q <= 1'b1;
    else
      wait_q <= wait_d;
  end

  assign waitrequest_out = wait_q;

endmodule

// file: verilog/gpio_port_regs.sv
// Purpose: Register file and pin control of an 8-bit port with pull-ups
//          and a 4-pin port with a clock output pin, on Avalon-MM.
// Assumes: Pin inputs and hw standby are asynchronous levels.
// Notes:   Every pin output comes from a flop.
`timescale 1ns/1ps
`include "gpio_params.svh"
module gpio_port_regs (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [21:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic hw_standby_in,
  input wire logic [7:0] p4_pin_in,
  output logic [7:0] p4_pin_out,
  output logic [7:0] p4_pin_oe_n_out,
  output logic [7:0] p4_pullup_on_out,
  output logic p4_data_bus_mode_out,
  input wire logic [3:0] p6_pin_in,
  output logic [3:0] p6_pin_out,
  output logic [3:0] p6_pin_oe_n_out
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Per bit: stored value where direction is 1, else the alternate
  function automatic logic [7:0] dir_mix(input logic [7:0] stored,
                                          input logic [7:0] alt,
                                          input logic [7:0] dir);
    dir_mix = (dir & stored) | (~dir & alt);
  endfunction

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  logic [12:0] sync_bus;
  logic [7:0] p4_pin_s;
  logic [3:0] p6_pin_s;
  logic hw_stby_s;

  sync2_bits #(
    .WIDTH(13)
  ) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in({hw_standby_in, p6_pin_in, p4_pin_in}),
    .sync_out(sync_bus)
  );

  assign p4_pin_s = sync_bus[7:0];
  assign p6_pin_s = sync_bus[11:8];
  assign hw_stby_s = sync_bus[12];

  // --------------------------------------------------------------------
  // Bus handshake and decode
  // --------------------------------------------------------------------
  logic prepare;
  logic accept;
  logic wr_take;
  gpio_types_pkg::reg_sel_t sel;

  avmm_wait_ack u_ack (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .request_in(avs_read_in | avs_write_in),
    .waitrequest_out(avs_waitrequest_out),
    .prepare_out(prepare),
    .accept_out(accept)
  );

  assign sel =
    (avs_address_in == {`P4_DIR_IDX, 2'b00}) ?
      gpio_types_pkg::SEL_P4_DIR :
    (avs_address_in == {`P4_DATA_IDX, 2'b00}) ?
      gpio_types_pkg::SEL_P4_DATA :
    (avs_address_in == {`P4_PULLUP_IDX, 2'b00}) ?
      gpio_types_pkg::SEL_P4_PULLUP :
    (avs_address_in == {`P6_DIR_IDX, 2'b00}) ?
      gpio_types_pkg::SEL_P6_DIR :
    (avs_address_in == {`P6_DATA_IDX, 2'b00}) ?
      gpio_types_pkg::SEL_P6_DATA :
    (avs_address_in == {`CTRL_IDX, 2'b00}) ?
      gpio_types_pkg::SEL_CTRL :
      gpio_types_pkg::SEL_NONE;

  // Only the low byte lane holds register bits
  assign wr_take = accept & avs_write_in & avs_byteenable_in[0];

  logic [7:0] wbyte;
  logic wr_p4_dir;
  logic wr_p4_data;
  logic wr_p4_pullup;
  logic wr_p6_dir;
  logic wr_p6_data;
  logic wr_ctrl;

  assign wbyte = avs_writedata_in[7:0];
  assign wr_p4_dir = wr_take & (sel == gpio_types_pkg::SEL_P4_DIR);
  assign wr_p4_data = wr_take & (sel == gpio_types_pkg::SEL_P4_DATA);
  assign wr_p4_pullup = wr_take & (sel == gpio_types_pkg::SEL_P4_PULLUP);
  assign wr_p6_dir = wr_take & (sel == gpio_types_pkg::SEL_P6_DIR);
  assign wr_p6_data = wr_take & (sel == gpio_types_pkg::SEL_P6_DATA);
  assign wr_ctrl = wr_take & (sel == gpio_types_pkg::SEL_CTRL);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [7:0] p4_dir_q, p4_dir_d;
  logic [7:0] p4_data_q, p4_data_d;
  logic [7:0] p4_pullup_q, p4_pullup_d;
  logic [7:0] p6_dir_q, p6_dir_d;
  logic [7:0] p6_data_q, p6_data_d;
  logic wide_q, wide_d;
  logic stop_q, stop_d;

  // Hw standby clears like reset; sw standby needs nothing: state is held
  assign p4_dir_d = hw_stby_s ? `P4_DIR_RST :
                    wr_p4_dir ? wbyte : p4_dir_q;
  assign p4_data_d = hw_stby_s ? `P4_DATA_RST :
                     wr_p4_data ? wbyte : p4_data_q;
  assign p4_pullup_d = hw_stby_s ? `P4_PULLUP_RST :
                       wr_p4_pullup ? wbyte : p4_pullup_q;
  // Bit 7 forced high; bits 6..3 kept for data readback
  assign p6_dir_d = hw_stby_s ? `P6_DIR_RST :
                    wr_p6_dir ? {1'b1, wbyte[6:0]} :
                    p6_dir_q;
  assign p6_data_d = hw_stby_s ? `P6_DATA_RST :
                     wr_p6_data ? {1'b1, wbyte[6:0]} :
                     p6_data_q;
  assign wide_d = hw_stby_s ? 1'b0 :
                  wr_ctrl ? wbyte[`CTRL_WIDE_BIT] : wide_q;
  assign stop_d = hw_stby_s ? 1'b0 :
                  wr_ctrl ? wbyte[`CTRL_STOP_BIT] : stop_q;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      p4_dir_q <= `P4_DIR_RST;
      p4_data_q <= `P4_DATA_RST;
      p4_pullup_q <= `P4_PULLUP_RST;
      p6_dir_q <= `P6_DIR_RST;
      p6_data_q <= `P6_DATA_RST;
      wide_q <= 1'b0;
      stop_q <= 1'b0;
    end
    else
    begin
      p4_dir_q <= p4_dir_d;
      p4_data_q <= p4_data_d;
      p4_pullup_q <= p4_pullup_d;
      p6_dir_q <= p6_dir_d;
      p6_data_q <= p6_data_d;
      wide_q <= wide_d;
      stop_q <= stop_d;
    end
  end

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  logic [7:0] p4_rd;
  logic [7:0] p6_low_rd;
  logic [7:0] p6_rd;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_byte;
  logic [31:0] readdata_q, readdata_d;

  assign p4_rd = dir_mix(p4_data_q, p4_pin_s, p4_dir_q);
  // Bits 6..3 have no pin: read 0 when direction is 0
  assign p6_low_rd = dir_mix(p6_data_q, {5'b0_0000, p6_pin_s[2:0]},
                             p6_dir_q);
  assign p6_rd = {stop_q ? p6_pin_s[3] : 1'b1, p6_low_rd[6:0]};
  assign ctrl_rd = {6'b00_0000, stop_q, wide_q};
  assign rd_byte =
    (sel == gpio_types_pkg::SEL_P4_DIR) ? `WO_READ_VAL :
    (sel == gpio_types_pkg::SEL_P4_DATA) ? p4_rd :
    (sel == gpio_types_pkg::SEL_P4_PULLUP) ? p4_pullup_q :
    (sel == gpio_types_pkg::SEL_P6_DIR) ? `WO_READ_VAL :
    (sel == gpio_types_pkg::SEL_P6_DATA) ? p6_rd :
    (sel == gpio_types_pkg::SEL_CTRL) ? ctrl_rd : 8'h00;
  assign readdata_d = (prepare & avs_read_in) ?
                      {24'h00_0000, rd_byte} : readdata_q;

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      readdata_q <= 32'h0000_0000;
    else
      readdata_q <= readdata_d;
  end

  assign avs_readdata_out = readdata_q;

  // --------------------------------------------------------------------
  // Pin drivers
  // --------------------------------------------------------------------
  // One register stage after the control registers, so a write shows
  // at the pins one edge after it is taken; outputs stay glitch free.
  logic release4;
  logic [7:0] p4_oe_n_q, p4_oe_n_d;
  logic [7:0] p4_out_q;
  logic [7:0] pullup_q, pullup_d;
  logic bus_mode_q;
  logic [3:0] p6_oe_n_q, p6_oe_n_d;
  logic [3:0] p6_out_q, p6_out_d;

  // Wide bus mode: port4 belongs to the external data bus
  assign release4 = hw_stby_s | wide_q;
  assign p4_oe_n_d = release4 ? 8'hFF : ~p4_dir_q;
  assign pullup_d = release4 ? 8'h00 :
                    ~p4_dir_q & p4_pullup_q;

  // Low pins: direction selects drive, data register gives the level
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_p6_low
      assign p6_oe_n_d[gi] = hw_stby_s | ~p6_dir_q[gi];
      assign p6_out_d[gi] = p6_data_q[gi];
    end
  endgenerate

  // Top pin: divided system clock out unless stopped
  assign p6_oe_n_d[3] = hw_stby_s | stop_q;
  assign p6_out_d[3] = ~p6_out_q[3];

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      p4_oe_n_q <= 8'hFF;
      p4_out_q <= 8'h00;
      pullup_q <= 8'h00;
      bus_mode_q <= 1'b0;
      p6_oe_n_q <= 4'hF;
      p6_out_q <= 4'h0;
    end
    else
    begin
      p4_oe_n_q <= p4_oe_n_d;
      p4_out_q <= p4_data_q;
      pullup_q <= pullup_d;
      bus_mode_q <= wide_q;
      p6_oe_n_q <= p6_oe_n_d;
      p6_out_q <= p6_out_d;
    end
  end

  assign p4_pin_oe_n_out = p4_oe_n_q;
  assign p4_pin_out = p4_out_q;
  assign p4_pullup_on_out = pullup_q;
  assign p4_data_bus_mode_out = bus_mode_q;
  assign p6_pin_oe_n_out = p6_oe_n_q;
  assign p6_pin_out = p6_out_q;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  a_wide_pullup_off: assert property (
    wide_q |=> p4_pullup_on_out == 8'h00)
    else $error("pull-up on in wide bus mode");
  a_pullup_gate: assert property (
    !wide_q && !hw_stby_s |=>
      p4_pullup_on_out == ($past(p4_pullup_q) & ~$past(p4_dir_q)))
    else $error("pull-up not gated by direction and enable");
  a_wide_release: assert property (
    wide_q |=> p4_pin_oe_n_out == 8'hFF)
    else $error("port4 driven in wide bus mode");
  a_p6dir_ones: assert property (
    accept && avs_read_in && sel == gpio_types_pkg::SEL_P6_DIR |->
      avs_readdata_out == 32'h0000_00FF)
    else $error("direction readback not all ones");
  a_p6dir_fixed: assert property (
    p6_dir_q[`P6_FIXED_BIT] && p6_data_q[`P6_FIXED_BIT])
    else $error("fixed bit 7 cleared");
  a_hw_standby_init: assert property (
    hw_stby_s |=> p4_data_q == 8'h00 && p4_pullup_q == 8'h00 &&
      p6_dir_q == 8'h80 && p6_data_q == 8'h80)
    else $error("hw standby did not initialise registers");
  a_p6_drive: assert property (
    !hw_stby_s |=> p6_pin_oe_n_out[2:0] == ~$past(p6_dir_q[2:0]) &&
      p6_pin_out[2:0] == $past(p6_data_q[2:0]))
    else $error("port6 low pin drive wrong");
  a_clock_pin: assert property (
    !hw_stby_s && !stop_q |=>
      !p6_pin_oe_n_out[3] && p6_pin_out[3] != $past(p6_pin_out[3]))
    else $error("clock output not toggling");
  a_bit7_read: assert property (
    accept && avs_read_in && sel == gpio_types_pkg::SEL_P6_DATA &&
      !$past(stop_q) |-> avs_readdata_out[7])
    else $error("data bit 7 read not 1");
  a_write_to_pin: assert property (
    wr_p4_data && !hw_stby_s ##1 !hw_stby_s |=>
      p4_pin_out == $past(avs_writedata_in[7:0], 2))
    else $error("write did not reach pins");
  a_wait_bound: assert property (
    (avs_read_in || avs_write_in) |-> ##[0:1] !avs_waitrequest_out)
    else $error("waitrequest held too long");

  c_p4_write: cover property (wr_p4_data);
  c_p6_read: cover property (
    accept && avs_read_in && sel == gpio_types_pkg::SEL_P6_DATA);
  c_wide_mode: cover property (wr_ctrl && wbyte[`CTRL_WIDE_BIT]);
  c_hw_standby: cover property (hw_stby_s);

endmodule

// file: verification/pin_board_model.sv
// Purpose: Board-side levels on the two port pin groups.
// Assumes: Lines with no drive and no pull-up toggle every cycle.
// Notes:   Design drive wins, then board drive, then pull-up.
`timescale 1ns/1ps
module pin_board_model (
  input wire logic clk_in,
  input wire logic [7:0] p4_drive_in,
  input wire logic [7:0] p4_oe_n_in,
  input wire logic [7:0] p4_pullup_in,
  input wire logic [7:0] p4_ext_en_in,
  input wire logic [7:0] p4_ext_val_in,
  input wire logic [3:0] p6_drive_in,
  input wire logic [3:0] p6_oe_n_in,
  input wire logic [3:0] p6_ext_val_in,
  output logic [7:0] p4_level_out,
  output logic [3:0] p6_level_out
);
  logic float_q = 1'b0;

  // Undriven lines must never look like a held value
  always @(posedge clk_in) float_q <= ~float_q;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!p4_oe_n_in[i]) p4_level_out[i] = p4_drive_in[i];
      else if (p4_ext_en_in[i]) p4_level_out[i] = p4_ext_val_in[i];
      else if (p4_pullup_in[i]) p4_level_out[i] = 1'b1;
      else p4_level_out[i] = float_q;
    end
    p6_level_out = (p6_drive_in & ~p6_oe_n_in) |
                   (p6_ext_val_in & p6_oe_n_in);
  end
endmodule

// file: verification/testbench.sv
// Purpose: Self-checking bench for the two-port pin block.
// Assumes: Master waits on waitrequest; pins settle within four edges.
// Notes:   Random register and pin values from a fixed seed.
`timescale 1ns/1ps
`include "gpio_params.svh"
module testbench;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [21:0] avs_address_in = 22'h00_0000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [3:0] avs_byteenable_in = 4'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic hw_standby_in = 1'b0;
  logic [7:0] p4_pin_in, p4_pin_out, p4_pin_oe_n_out, p4_pullup_on_out;
  logic p4_data_bus_mode_out;
  logic [3:0] p6_pin_in, p6_pin_out, p6_pin_oe_n_out;
  logic [7:0] p4_ext_en = 8'hFF;
  logic [7:0] p4_ext_val = 8'h5A;
  logic [3:0] p6_ext = 4'hA;
  logic [31:0] seed = 32'h0000_06a7;
  logic [31:0] r;
  logic [7:0] d4, dir4, pu, ev, d6, dir6, rd;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;

  always #4 clk_in = ~clk_in;

  gpio_port_regs DUT (.clk_in(clk_in), .resetn_in(resetn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .hw_standby_in(hw_standby_in), .p4_pin_in(p4_pin_in),
    .p4_pin_out(p4_pin_out), .p4_pin_oe_n_out(p4_pin_oe_n_out),
    .p4_pullup_on_out(p4_pullup_on_out),
    .p4_data_bus_mode_out(p4_data_bus_mode_out),
    .p6_pin_in(p6_pin_in), .p6_pin_out(p6_pin_out),
    .p6_pin_oe_n_out(p6_pin_oe_n_out));

  pin_board_model board (.clk_in(clk_in), .p4_drive_in(p4_pin_out),
    .p4_oe_n_in(p4_pin_oe_n_out), .p4_pullup_in(p4_pullup_on_out),
    .p4_ext_en_in(p4_ext_en), .p4_ext_val_in(p4_ext_val),
    .p6_drive_in(p6_pin_out), .p6_oe_n_in(p6_pin_oe_n_out),
    .p6_ext_val_in(p6_ext), .p4_level_out(p4_pin_in),
    .p6_level_out(p6_pin_in));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] exp_p4(input logic [7:0] d, dir, lvl);
    return (d & dir) | (lvl & ~dir);
  endfunction

  function automatic logic [7:0] exp_p6(input logic [7:0] d, dir,
                                        input logic [3:0] lvl,
                                        input logic stop);
    return {stop ? lvl[3] : 1'b1, d[6:3] & dir[6:3],
            (d[2:0] & dir[2:0]) | (lvl[2:0] & ~dir[2:0])};
  endfunction

  task automatic report_and_stop();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [19:0] idx,
                     input logic [7:0] wd, input logic be,
                     output logic [7:0] rdata);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= {idx, 2'b00};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= {24'h00_0000, wd};
    avs_byteenable_in <= {3'b000, be};
    do
    begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      n_fail++;
      report_and_stop();
    end
    rdata = avs_readdata_out[7:0];
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic wr(input logic [19:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    bus(1'b1, idx, d, 1'b1, unused);
  endtask

  task automatic rd_chk(input logic [19:0] idx, input logic [7:0] exp,
                        input string what);
    logic [7:0] got;
    bus(1'b0, idx, 8'h00, 1'b1, got);
    check(what, exp, got);
  endtask

  // Covers the pin input synchroniser plus the pin output flop
  task automatic settle();
    repeat (4) @(posedge clk_in);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    settle();
    check("p4_oe_n", 8'hFF, p4_pin_oe_n_out);
    check("p4_pullup", 8'h00, p4_pullup_on_out);
    check("p6_oe_n", 8'h07, {4'h0, p6_pin_oe_n_out});
    rd_chk(`P4_DATA_IDX, 8'h5A, "p4_data");
    rd_chk(`P4_PULLUP_IDX, 8'h00, "p4_pullup_reg");
    rd_chk(`P6_DIR_IDX, 8'hFF, "p6_dir");
    rd_chk(`P6_DATA_IDX, 8'h82, "p6_data");
    wr(`P4_DIR_IDX, 8'hFF);
    wr(`P6_DIR_IDX, 8'h00);
    settle();
    check("p4_out", 8'h00, p4_pin_out);
    $display("test reset done");

    repeat (24)
    begin
      r = rnd();
      dir4 = r[7:0];
      d4 = r[15:8];
      pu = r[23:16];
      ev = r[31:24] & ~pu;
      p4_ext_en <= ~pu;
      p4_ext_val <= ev;
      wr(`P4_DIR_IDX, dir4);
      wr(`P4_DATA_IDX, d4);
      wr(`P4_PULLUP_IDX, pu);
      r = rnd();
      dir6 = r[7:0];
      d6 = r[15:8];
      p6_ext <= r[19:16];
      wr(`P6_DIR_IDX, dir6);
      wr(`P6_DATA_IDX, d6);
      settle();
      check("p4_oe_n", ~dir4, p4_pin_oe_n_out);
      check("p4_out", d4, p4_pin_out);
      check("p4_pullup", pu & ~dir4, p4_pullup_on_out);
      check("p6_oe_n", {5'h00, ~dir6[2:0]}, {4'h0, p6_pin_oe_n_out});
      check("p6_out", {5'h00, d6[2:0] & dir6[2:0]},
            {5'h00, p6_pin_out[2:0] & dir6[2:0]});
      rd_chk(`P4_DATA_IDX, exp_p4(d4, dir4, pu | ev), "p4_data");
      rd_chk(`P6_DIR_IDX, 8'hFF, "p6_dir");
      rd_chk(`P6_DATA_IDX, exp_p6(d6, dir6, p6_ext, 1'b0), "p6_data");
    end
    $display("test random done");

    wr(`P4_DIR_IDX, 8'hFF);
    wr(`P4_DATA_IDX, 8'h3C);
    settle();
    wr(`P4_DATA_IDX, 8'hC3);
    #1;
    check("p4_out_early", 8'h3C, p4_pin_out);
    @(posedge clk_in);
    #1;
    check("p4_out_late", 8'hC3, p4_pin_out);
    $display("test timing done");

    p4_ext_en <= 8'h00;
    wr(`P4_DIR_IDX, 8'h00);
    wr(`P4_PULLUP_IDX, 8'hFF);
    wr(`CTRL_IDX, 8'h01 << `CTRL_WIDE_BIT);
    settle();
    check("bus_mode", 8'h01, {7'h00, p4_data_bus_mode_out});
    check("p4_oe_n", 8'hFF, p4_pin_oe_n_out);
    check("p4_pullup", 8'h00, p4_pullup_on_out);
    wr(`CTRL_IDX, 8'h00);
    settle();
    check("p4_pullup", 8'hFF, p4_pullup_on_out);
    bus(1'b1, `P4_PULLUP_IDX, 8'h00, 1'b0, rd);
    rd_chk(`P4_PULLUP_IDX, 8'hFF, "p4_pullup_be");
    rd_chk(20'h0_0000, 8'h00, "unmapped");
    $display("test bus mode done");

    wr(`P6_DIR_IDX, 8'h00);
    wr(`CTRL_IDX, 8'h01 << `CTRL_STOP_BIT);
    for (int v = 0; v < 2; v++)
    begin
      p6_ext <= {v[0], 3'b101};
      settle();
      check("p6_top_oe_n", 8'h01, {7'h00, p6_pin_oe_n_out[3]});
      rd_chk(`P6_DATA_IDX, exp_p6(8'h00, 8'h00, {v[0], 3'b101}, 1'b1),
             "p6_data_stop");
    end
    wr(`CTRL_IDX, 8'h00);
    settle();
    check("p6_top_oe_n", 8'h00, {7'h00, p6_pin_oe_n_out[3]});
    $display("test clock pin done");

    wr(`P4_DIR_IDX, 8'hFF);
    wr(`P4_DATA_IDX, 8'hA5);
    wr(`P6_DIR_IDX, 8'hFF);
    wr(`P6_DATA_IDX, 8'h7F);
    hw_standby_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    #1;
    check("p4_oe_n_stby", 8'hFF, p4_pin_oe_n_out);
    check("p4_pullup_stby", 8'h00, p4_pullup_on_out);
    @(posedge clk_in);
    hw_standby_in <= 1'b0;
    settle();
    rd_chk(`P4_PULLUP_IDX, 8'h00, "p4_pullup_reg");
    rd_chk(`CTRL_IDX, 8'h00, "ctrl");
    rd_chk(`P6_DATA_IDX, exp_p6(8'h80, 8'h80, p6_ext, 1'b0),
           "p6_data");
    wr(`P6_DIR_IDX, 8'hFF);
    rd_chk(`P6_DATA_IDX, 8'h80, "p6_data");
    wr(`P4_DIR_IDX, 8'hFF);
    settle();
    check("p4_out", 8'h00, p4_pin_out);
    $display("test standby done");
    report_and_stop();
  end
endmodule
